/* hdl/uwb_pkg.sv */
/*
 * Shared constants of the serial port: register indexes, field positions,
 * reset values, divider counts and the enumerations of modes and states.
 * Assumes a single 100 MHz peripheral clock.
 */
package uwb_pkg;
  // register indexes; the bus byte address is four times the index
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] IDX_SERIAL_BUFFER = 8'h99;
  localparam logic [7:0] IDX_RELOAD_VALUE = 8'h9A;
  localparam logic [7:0] IDX_RATE_GEN_CONTROL = 8'h9B;
  localparam logic [7:0] IDX_SLAVE_ADDRESS = 8'hA9;
  localparam logic [7:0] IDX_SLAVE_ADDRESS_MASK = 8'hB9;

  localparam int SC_MODE_HI = 7;
  localparam int SC_MODE_LO = 6;
  localparam int SC_MULTI = 5;
  localparam int SC_RX_ALLOW = 4;
  localparam int SC_TX9 = 3;
  localparam int SC_RX9 = 2;
  localparam int SC_TX_DONE = 1;
  localparam int SC_RX_DONE = 0;
  localparam int PC_DOUBLER = 7;
  localparam int PC_ERR_VIEW = 6;
  localparam int RG_RUN = 4;
  localparam int RG_TX_SEL = 3;
  localparam int RG_RX_SEL = 2;
  localparam int RG_FAST = 1;
  localparam int RG_M0_SRC = 0;

  localparam logic [7:0] SERIAL_CONTROL_RST = 8'h00;
  localparam logic [7:0] SLAVE_ADDRESS_RST = 8'h00;
  localparam logic [7:0] SLAVE_MASK_RST = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [4:0] RATE_GEN_CONTROL_RST = 5'h00;
  localparam logic [1:0] POWER_CONTROL_RST = 2'h0;

  // generator prescale: 2 x 2 x 6^(1-fast), halved by the doubler
  localparam int BRG_QUAD = 4;
  localparam int BRG_SLOW = 6;
  localparam logic [4:0] PRE_SLOW_X1 = 5'(BRG_QUAD * BRG_SLOW);
  localparam logic [4:0] PRE_SLOW_X2 = 5'(BRG_QUAD * BRG_SLOW / 2);
  localparam logic [4:0] PRE_FAST_X1 = 5'(BRG_QUAD);
  localparam logic [4:0] PRE_FAST_X2 = 5'(BRG_QUAD / 2);
  localparam logic [7:0] BRG_TOP = 8'hFF;

  localparam int M0_DIV = 6;
  localparam logic [1:0] M0_HALF_LAST = 2'(M0_DIV / 2 - 1);
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_POINT = 4'h7;
  localparam logic [3:0] LAST_BIT8 = 4'h9;
  localparam logic [3:0] LAST_BIT9 = 4'hA;
  localparam logic [2:0] M0_LAST_BIT = 3'h7;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_UART8 = 2'b01,
    MODE_FIXED9 = 2'b10,
    MODE_VAR9 = 2'b11
  } uwb_mode_e;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_UART = 2'b01,
    TX_SHIFT = 2'b11
  } uwb_tx_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b11
  } uwb_rx_e;
endpackage : uwb_pkg

/* hdl/uwb_brg_if.sv */
/*
 * Control and overflow link between the register file and the rate generator.
 * Assumes both ends run on the same clock.
 */
interface uwb_brg_if;
  logic run;
  logic fast;
  logic dbl;
  logic [7:0] reload;
  logic ovf;
  modport ctl (output run, output fast, output dbl, output reload, input ovf);
  modport gen (input run, input fast, input dbl, input reload, output ovf);
endinterface : uwb_brg_if

/* hdl/uwb_brg.sv */
/*
 * Internal rate generator: prescaler plus 8-bit reloading counter; one pulse
 * per overflow, used as the 16x oversampling tick. Assumes clk is the
 * peripheral clock and ce freezes it.
 */
module uwb_brg
  import uwb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  uwb_brg_if.gen brg
);
  logic [4:0] pre_q;
  logic [4:0] pre_last;
  logic [7:0] cnt_q;
  logic ovf_q;
  logic pre_tick;

  always_comb begin
    case ({brg.fast, brg.dbl})
      2'b00: pre_last = PRE_SLOW_X1 - 5'h01;
      2'b01: pre_last = PRE_SLOW_X2 - 5'h01;
      2'b10: pre_last = PRE_FAST_X1 - 5'h01;
      default: pre_last = PRE_FAST_X2 - 5'h01;
    endcase
  end

  assign pre_tick = brg.run && (pre_q >= pre_last);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 5'h00;
    end else if (ce) begin
      if (!brg.run || pre_tick) begin
        pre_q <= 5'h00;
      end else begin
        pre_q <= pre_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      ovf_q <= 1'b0;
    end else if (ce) begin
      ovf_q <= 1'b0;
      if (pre_tick) begin
        if (cnt_q == BRG_TOP) begin
          cnt_q <= brg.reload;
          ovf_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end

  assign brg.ovf = ovf_q;
endmodule : uwb_brg

/* hdl/uwb_rx.sv */
/*
 * Asynchronous frame receiver, 16x oversampled with a mid-bit sample.
 * Assumes rxd synchronous to clk and tick16 a one-cycle pulse.
 */
module uwb_rx
  import uwb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tick16,
  input wire logic rxd,
  input wire logic enable,
  input wire logic nine,
  input wire logic early,
  output logic done,
  output logic [7:0] data,
  output logic bit9,
  output logic stop_ok,
  output logic stop_seen
);
  uwb_rx_e st_q;
  logic [3:0] ph_q;
  logic [3:0] idx_q;
  logic [8:0] sh_q;
  logic [8:0] sh_d;
  logic prev_q;
  logic sample;
  logic [3:0] last;
  logic emitted_q;

  assign sample = tick16 && (ph_q == SAMPLE_POINT);
  assign sh_d = {rxd, sh_q[8:1]};
  assign last = nine ? LAST_BIT9 : LAST_BIT8;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b1;
    end else if (ce) begin
      prev_q <= rxd;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= RX_IDLE;
      ph_q <= 4'h0;
      idx_q <= 4'h0;
      sh_q <= 9'h000;
      emitted_q <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        st_q <= RX_IDLE;
      end else begin
        case (st_q)
          RX_IDLE: begin
            ph_q <= 4'h0;
            idx_q <= 4'h1;
            emitted_q <= 1'b0;
            if (prev_q && !rxd) begin
              st_q <= RX_START;
            end
          end
          RX_START: begin
            if (tick16) begin
              ph_q <= ph_q + 4'h1;
            end
            // glitch shorter than half a bit is no start
            if (sample && rxd) begin
              st_q <= RX_IDLE;
            end else if (tick16 && ph_q == OVS_LAST) begin
              st_q <= RX_BITS;
            end
          end
          RX_BITS: begin
            if (tick16) begin
              ph_q <= ph_q + 4'h1;
            end
            if (tick16 && ph_q == OVS_LAST) begin
              idx_q <= idx_q + 4'h1;
            end
            if (sample) begin
              if (idx_q <= LAST_BIT8) begin
                sh_q <= sh_d;
              end
              if (idx_q == LAST_BIT8 && nine && early) begin
                emitted_q <= 1'b1;
              end
              if (idx_q == last) begin
                st_q <= RX_IDLE;
              end
            end
          end
          default: st_q <= RX_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      data <= 8'h00;
      bit9 <= 1'b0;
      stop_ok <= 1'b0;
      stop_seen <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (enable && st_q == RX_BITS && sample) begin
        if (idx_q == LAST_BIT8 && (!nine || early)) begin
          done <= 1'b1;
          data <= sh_d[7:0];
          bit9 <= rxd;
          stop_ok <= rxd;
          stop_seen <= !nine;
        end else if (idx_q == LAST_BIT9 && nine) begin
          done <= !emitted_q;
          data <= sh_q[7:0];
          bit9 <= sh_q[8];
          stop_ok <= rxd;
          stop_seen <= 1'b1;
        end
      end
    end
  end
endmodule : uwb_rx

/* hdl/uwb_top.sv */
/*
 * Serial port with internal rate generator behind a classic Wishbone slave:
 * shift-register mode, 8-bit and 9-bit UART, framing error capture and
 * multiprocessor address recognition. Assumes all inputs synchronous to
 * CLOCK; the data pin is two-way (input, output, output enable).
 */
// The Wishbone register port is this design's own decision.
module uwb_top
  import uwb_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [9:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic SER_TXD,
  input wire logic SER_DATA_I,
  output logic SER_DATA_O,
  output logic SER_DATA_OE
);
  uwb_brg_if brg_if ();

  logic ack_q;
  logic [7:0] rdat_q;
  logic req;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wdat;
  logic [7:0] sc_rd;
  logic mode_hi_q, mode_lo_q, multi_q, allow_q, tx9_q, rx9_q, ti_q, ri_q, fe_q;
  logic dbl_q, err_view_q;
  logic [7:0] reload_q, slave_address_q, smask_q, rx_buf_q;
  logic [4:0] rgc_q;
  uwb_mode_e mode;
  logic mode0, nine, var_rate, multi_eff;
  logic m2_tog_q, m2_tick, tx_t16, rx_t16;
  logic [1:0] m0_div_q;
  logic m0_half;
  uwb_tx_e tx_st_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_ph_q, tx_idx_q, tx_last;
  logic m0_ph_q, m0_rx_q;
  logic tx_start, m0_rx_start, ti_set, ri_set_m0, ri_set_uart, fe_set;
  logic txd_q, dout_q, doe_q;
  logic rx_done, rx_bit9, rx_stop_ok, rx_stop_seen;
  logic [7:0] rx_data;
  logic [7:0] bcast;
  logic addr_ok, accept;

  // bus slave: ack one cycle after the request, write lands on the ack edge
  assign req = WB_CYC_I && WB_STB_I;
  assign idx = WB_ADR_I[9:2];
  assign wdat = WB_DAT_I[7:0];
  assign wr = req && WB_WE_I && ack_q && WB_SEL_I[0];

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_q <= 1'b0;
    end else if (CE) begin
      ack_q <= req && !ack_q;
    end
  end

  always_comb begin
    sc_rd = {err_view_q ? fe_q : mode_hi_q, mode_lo_q, multi_q, allow_q, tx9_q, rx9_q, ti_q, ri_q};
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdat_q <= 8'h00;
    end else if (CE && req && !ack_q) begin
      case (idx)
        IDX_POWER_CONTROL: rdat_q <= {dbl_q, err_view_q, 6'h00};
        IDX_SERIAL_CONTROL: rdat_q <= sc_rd;
        IDX_SERIAL_BUFFER: rdat_q <= rx_buf_q;
        IDX_RELOAD_VALUE: rdat_q <= reload_q;
        IDX_RATE_GEN_CONTROL: rdat_q <= {3'h0, rgc_q};
        IDX_SLAVE_ADDRESS: rdat_q <= slave_address_q;
        IDX_SLAVE_ADDRESS_MASK: rdat_q <= smask_q;
        default: rdat_q <= 8'h00;
      endcase
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = {24'h000000, rdat_q};

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      dbl_q <= POWER_CONTROL_RST[1];
      err_view_q <= POWER_CONTROL_RST[0];
      reload_q <= RELOAD_RST;
      rgc_q <= RATE_GEN_CONTROL_RST;
      slave_address_q <= SLAVE_ADDRESS_RST;
      smask_q <= SLAVE_MASK_RST;
    end else if (CE && wr) begin
      case (idx)
        IDX_POWER_CONTROL: begin
          dbl_q <= wdat[PC_DOUBLER];
          err_view_q <= wdat[PC_ERR_VIEW];
        end
        IDX_RELOAD_VALUE: reload_q <= wdat;
        IDX_RATE_GEN_CONTROL: rgc_q <= wdat[4:0];
        IDX_SLAVE_ADDRESS: slave_address_q <= wdat;
        IDX_SLAVE_ADDRESS_MASK: smask_q <= wdat;
        default: ;
      endcase
    end
  end

  // serial control: hardware set beats a software clear in the same cycle
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      {mode_hi_q, mode_lo_q, multi_q, allow_q, tx9_q, rx9_q, ti_q, ri_q} <= SERIAL_CONTROL_RST;
      fe_q <= 1'b0;
    end else if (CE) begin
      if (wr && idx == IDX_SERIAL_CONTROL) begin
        if (err_view_q) begin
          fe_q <= wdat[SC_MODE_HI];
        end else begin
          mode_hi_q <= wdat[SC_MODE_HI];
        end
        mode_lo_q <= wdat[SC_MODE_LO];
        multi_q <= wdat[SC_MULTI];
        allow_q <= wdat[SC_RX_ALLOW];
        tx9_q <= wdat[SC_TX9];
        rx9_q <= wdat[SC_RX9];
        ti_q <= wdat[SC_TX_DONE];
        ri_q <= wdat[SC_RX_DONE];
      end
      if (fe_set) begin
        fe_q <= 1'b1;
      end
      if (ti_set) begin
        ti_q <= 1'b1;
      end
      if (ri_set_m0 || ri_set_uart) begin
        ri_q <= 1'b1;
      end
      if (ri_set_uart) begin
        rx9_q <= rx_bit9;
      end
    end
  end

  assign mode = uwb_mode_e'({mode_hi_q, mode_lo_q});
  assign mode0 = (mode == MODE_SHIFT);
  assign nine = mode_hi_q;
  assign var_rate = mode_lo_q;
  assign multi_eff = multi_q && !mode0;

  // rate generator and its control bits
  assign brg_if.run = rgc_q[RG_RUN];
  assign brg_if.fast = rgc_q[RG_FAST];
  assign brg_if.dbl = dbl_q;
  assign brg_if.reload = reload_q;

  uwb_brg u_brg (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .ce(CE),
    .brg(brg_if)
  );

  // mode 2: 16x tick at clock/2, or every clock when doubled
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      m2_tog_q <= 1'b0;
      m0_div_q <= 2'h0;
    end else if (CE) begin
      m2_tog_q <= !m2_tog_q;
      m0_div_q <= (m0_div_q == M0_HALF_LAST) ? 2'h0 : m0_div_q + 2'h1;
    end
  end

  assign m2_tick = dbl_q || m2_tog_q;
  // no timer sources here: modes 1 and 3 sit idle unless the generator is selected
  assign tx_t16 = (mode == MODE_FIXED9) ? m2_tick : (var_rate && rgc_q[RG_TX_SEL] && brg_if.ovf);
  assign rx_t16 = (mode == MODE_FIXED9) ? m2_tick : (var_rate && rgc_q[RG_RX_SEL] && brg_if.ovf);
  assign m0_half = rgc_q[RG_M0_SRC] ? brg_if.ovf : (m0_div_q == M0_HALF_LAST);

  // transmitter and mode-0 shifter; a buffer write while busy is dropped
  assign tx_start = wr && idx == IDX_SERIAL_BUFFER && tx_st_q == TX_IDLE;
  assign m0_rx_start = mode0 && allow_q && !ri_q && tx_st_q == TX_IDLE && !tx_start;
  assign tx_last = nine ? LAST_BIT9 : LAST_BIT8;

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= 11'h7FF;
      tx_ph_q <= 4'h0;
      tx_idx_q <= 4'h0;
      m0_ph_q <= 1'b0;
      m0_rx_q <= 1'b0;
    end else if (CE) begin
      case (tx_st_q)
        TX_IDLE: begin
          tx_ph_q <= 4'h0;
          tx_idx_q <= 4'h0;
          m0_ph_q <= 1'b0;
          if (tx_start) begin
            tx_sh_q <= {1'b1, nine ? tx9_q : 1'b1, wdat, 1'b0};
            m0_rx_q <= 1'b0;
            if (mode0) begin
              tx_sh_q <= {3'h7, wdat};
              tx_st_q <= TX_SHIFT;
            end else begin
              tx_st_q <= TX_UART;
            end
          end else if (m0_rx_start) begin
            m0_rx_q <= 1'b1;
            tx_st_q <= TX_SHIFT;
          end
        end
        TX_UART: begin
          if (tx_t16) begin
            tx_ph_q <= tx_ph_q + 4'h1;
            if (tx_ph_q == OVS_LAST) begin
              tx_sh_q <= {1'b1, tx_sh_q[10:1]};
              tx_idx_q <= tx_idx_q + 4'h1;
              if (tx_idx_q == tx_last) begin
                tx_st_q <= TX_IDLE;
              end
            end
          end
        end
        TX_SHIFT: begin
          if (m0_half) begin
            m0_ph_q <= !m0_ph_q;
            if (!m0_ph_q && m0_rx_q) begin
              tx_sh_q[7:0] <= {SER_DATA_I, tx_sh_q[7:1]};
            end
            if (m0_ph_q) begin
              if (!m0_rx_q) begin
                tx_sh_q[7:0] <= {1'b1, tx_sh_q[7:1]};
              end
              tx_idx_q <= tx_idx_q + 4'h1;
              if (tx_idx_q[2:0] == M0_LAST_BIT) begin
                tx_st_q <= TX_IDLE;
              end
            end
          end
          if (m0_rx_q && !allow_q) begin
            tx_st_q <= TX_IDLE;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // done flags: stop-bit start in uart modes, end of 8th bit in mode 0
  assign ti_set = CE && ((tx_st_q == TX_UART && tx_t16 && tx_ph_q == OVS_LAST && tx_idx_q == tx_last - 4'h1)
                  || (tx_st_q == TX_SHIFT && !m0_rx_q && m0_half && m0_ph_q
                      && tx_idx_q[2:0] == M0_LAST_BIT));
  assign ri_set_m0 = CE && tx_st_q == TX_SHIFT && m0_rx_q && allow_q && m0_half && m0_ph_q
                     && tx_idx_q[2:0] == M0_LAST_BIT;

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      txd_q <= 1'b1;
      dout_q <= 1'b1;
      doe_q <= 1'b0;
    end else if (CE) begin
      txd_q <= (tx_st_q == TX_UART) ? tx_sh_q[0] : (tx_st_q == TX_SHIFT) ? m0_ph_q : 1'b1;
      dout_q <= (tx_st_q == TX_SHIFT && !m0_rx_q) ? tx_sh_q[0] : 1'b1;
      doe_q <= (tx_st_q == TX_SHIFT && !m0_rx_q);
    end
  end

  assign SER_TXD = txd_q;
  assign SER_DATA_O = dout_q;
  assign SER_DATA_OE = doe_q;

  // uart receiver; early hand-off only when error detection is off
  uwb_rx u_rx (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .ce(CE),
    .tick16(rx_t16),
    .rxd(SER_DATA_I),
    .enable(allow_q && !mode0),
    .nine(nine),
    .early(!err_view_q),
    .done(rx_done),
    .data(rx_data),
    .bit9(rx_bit9),
    .stop_ok(rx_stop_ok),
    .stop_seen(rx_stop_seen)
  );

  // given address under mask, or broadcast = address or mask
  assign bcast = slave_address_q | smask_q;
  assign addr_ok = (((rx_data ^ slave_address_q) & smask_q) == 8'h00) || ((rx_data & bcast) == bcast);
  // an unread byte is never overwritten
  assign accept = !ri_q && (!multi_eff || (rx_bit9 && addr_ok));
  assign ri_set_uart = CE && rx_done && accept;
  assign fe_set = CE && rx_done && rx_stop_seen && !rx_stop_ok && err_view_q;

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_buf_q <= 8'h00;
    end else if (CE) begin
      if (ri_set_uart) begin
        rx_buf_q <= rx_data;
      end else if (ri_set_m0) begin
        // all eight samples are already in; no further shift here
        rx_buf_q <= tx_sh_q[7:0];
      end
    end
  end
endmodule : uwb_top

/* tb/uwb_properties.sv */
/* Checker of the serial port's bus answers and pin levels, with its bind.
   Sees only the ports of uwb_top; tracks mode bits from bus writes. */
module uwb_properties
  import uwb_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [9:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic SER_TXD,
  input wire logic SER_DATA_I,
  input wire logic SER_DATA_O,
  input wire logic SER_DATA_OE
);
  logic [1:0] mode_q;
  logic view_q;
  logic [7:0] sa_q;
  logic wr_hit;
  assign wr_hit = WB_ACK_O && WB_WE_I && WB_SEL_I[0];
  // bit 7 lands in the mode only while the error view is off
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_q <= 2'h0;
      view_q <= 1'h0;
      sa_q <= SLAVE_ADDRESS_RST;
    end else if (wr_hit) begin
      if (WB_ADR_I[9:2] == IDX_SERIAL_CONTROL) begin
        mode_q[0] <= WB_DAT_I[SC_MODE_LO];
        if (!view_q) begin
          mode_q[1] <= WB_DAT_I[SC_MODE_HI];
        end
      end
      if (WB_ADR_I[9:2] == IDX_POWER_CONTROL) begin
        view_q <= WB_DAT_I[PC_ERR_VIEW];
      end
      if (WB_ADR_I[9:2] == IDX_SLAVE_ADDRESS) begin
        sa_q <= WB_DAT_I[7:0];
      end
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("no ack after request");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  a_unmapped_zero: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == 10'h3FC |-> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
  a_slave_echo: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I[9:2] == IDX_SLAVE_ADDRESS
    |-> WB_DAT_O[7:0] == sa_q) else $error("slave address readback wrong");
  a_oe_shift: assert property (SER_DATA_OE |-> mode_q == 2'h0)
    else $error("data pin driven outside shift mode");
  a_pin_idle: assert property (mode_q != 2'h0 && $past(mode_q) != 2'h0 |-> SER_DATA_O && !SER_DATA_OE)
    else $error("data pin active in uart mode");
  a_start_len: assert property ($fell(SER_TXD) && mode_q == 2'h2 |-> !SER_TXD [*8])
    else $error("start bit too short");
  a_reset_idle: assert property ($rose(RESET_N) |-> SER_TXD && !SER_DATA_OE && !WB_ACK_O)
    else $error("pins not idle after reset");
endmodule : uwb_properties

bind uwb_top uwb_properties i_chk (.CLOCK(CLOCK), .RESET_N(RESET_N), .CE(CE), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SER_TXD(SER_TXD), .SER_DATA_I(SER_DATA_I),
  .SER_DATA_O(SER_DATA_O), .SER_DATA_OE(SER_DATA_OE));

/* tb/uwb_peer.sv */
/* Remote serial peer: sends frames on the receive line, collects frames
   from the transmit line. Assumes the bench sets bit time and frame size. */
module uwb_peer (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  int bit_clks = 32;
  int nb = 10;
  logic listen = 1'h0;
  int got[$];
  initial rxd = 1'h1;
  // start, bits LSB first, then stop; line idles high between frames
  task automatic send(input int v, input int n, input logic stp);
    for (int i = -1; i <= n; i++) begin
      rxd <= (i < 0) ? 1'h0 : (i == n) ? stp : v[i];
      repeat (bit_clks) @(posedge clk);
    end
    rxd <= 1'h1;
  endtask : send
  // mid-bit sampling tolerates almost half a bit of phase slip
  always @(negedge txd) begin : catch_frame
    int v;
    if (listen) begin
      v = 0;
      repeat (bit_clks / 2) @(posedge clk);
      for (int i = 0; i < nb; i++) begin
        repeat (bit_clks) @(posedge clk);
        v[i] = txd;
      end
      got.push_back(v);
    end
  end
endmodule : uwb_peer

/* tb/test_uart_with_internal_baud_generator.sv */
/* Self-checking bench of the serial port: bus tasks, expected flags and
   frames, and a remote peer. Assumes uwb_top and uwb_peer compiled first. */
module test_uart_with_internal_baud_generator
  import uwb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] A_SC = {IDX_SERIAL_CONTROL, 2'h0};
  localparam logic [9:0] A_BUF = {IDX_SERIAL_BUFFER, 2'h0};
  localparam logic [9:0] A_RL = {IDX_RELOAD_VALUE, 2'h0};
  localparam logic [9:0] A_RG = {IDX_RATE_GEN_CONTROL, 2'h0};
  localparam logic [9:0] A_PC = {IDX_POWER_CONTROL, 2'h0};
  localparam logic [9:0] A_SA = {IDX_SLAVE_ADDRESS, 2'h0};
  localparam logic [9:0] A_SM = {IDX_SLAVE_ADDRESS_MASK, 2'h0};
  logic clk = 1'h0;
  logic rst_n, cyc, stb, we, ack, txd, d_o, d_oe, rxd, pin, b9;
  logic [9:0] adr;
  logic [31:0] dat, dat_o;
  logic [7:0] d, q, m0_q;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc_cnt = 0;
  always #5 clk = ~clk;
  assign pin = d_oe ? d_o : rxd;
  uwb_top i_dut (.CLOCK(clk), .RESET_N(rst_n), .CE(1'h1), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .SER_TXD(txd),
    .SER_DATA_I(pin), .SER_DATA_O(d_o), .SER_DATA_OE(d_oe));
  uwb_peer i_peer (.clk(clk), .txd(txd), .rxd(rxd));
  // mode 0 data only changes with the falling shift clock
  always @(posedge txd) begin
    if (d_oe) begin
      m0_q <= {d_o, m0_q[7:1]};
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check
  // request held until ack is sampled, then released for a cycle
  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= {24'h0, wd};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 50);
    rd = dat_o[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n >= 50) check(32'h0, 32'h1, "bus timeout");
  endtask : wb
  task automatic wr(input logic [9:0] a, input logic [7:0] wd);
    logic [7:0] r;
    wb(1'h1, a, wd, r);
  endtask : wr
  task automatic rdc(input logic [9:0] a, input logic [7:0] e, input string m);
    logic [7:0] r;
    wb(1'h0, a, 8'h00, r);
    check({24'h0, r}, {24'h0, e}, m);
  endtask : rdc
  task automatic wait_got();
    int n;
    n = 0;
    while (i_peer.got.size() == 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_got
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  // whole run needs about 5700 cycles
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    {rst_n, cyc, stb, we, adr, dat} = '0;
    d = 8'($urandom(32'h1A32));
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    rdc(A_SC, 8'h00, "control reset");
    rdc(A_SM, 8'h00, "mask reset");
    wr(10'h3FC, 8'hFF);
    rdc(10'h3FC, 8'h00, "unmapped");
    wr(A_SA, d);
    rdc(A_SA, d, "slave address");
    $display("test registers done");
    i_peer.listen = 1'h1;
    wr(A_SC, 8'h98);
    d = 8'($urandom);
    wr(A_BUF, d);
    wait_got();
    check(i_peer.got.pop_front(), {22'h0, 2'h3, d}, "mode 2 frame");
    rdc(A_SC, 8'h9A, "mode 2 tx done");
    wr(A_SC, 8'h98);
    b9 = 1'($urandom);
    i_peer.send({b9, d}, 9, 1'h1);
    rdc(A_SC, {5'h13, b9, 2'h1}, "mode 2 rx flags");
    rdc(A_BUF, d, "mode 2 rx data");
    wr(A_SC, 8'h88);
    i_peer.send(9'h15A, 9, 1'h1);
    rdc(A_SC, 8'h88, "rx disabled");
    wr(A_SA, 8'h5A);
    wr(A_SM, 8'hFF);
    wr(A_SC, 8'hB8);
    i_peer.send(9'h15B, 9, 1'h1);
    rdc(A_SC, 8'hB8, "address mismatch");
    i_peer.send(9'h15A, 9, 1'h1);
    rdc(A_SC, 8'hBD, "address match");
    rdc(A_BUF, 8'h5A, "address byte");
    $display("test mode 2 done");
    // overflow every 4 x 2 clocks, 16 overflows per bit
    wr(A_RL, 8'hFE);
    wr(A_RG, 8'h1E);
    // first overflow needs a full count up from zero
    repeat (1040) @(posedge clk);
    wr(A_SC, 8'h50);
    i_peer.nb = 9;
    i_peer.bit_clks = 128;
    d = 8'($urandom);
    wr(A_BUF, d);
    q = 8'($urandom);
    i_peer.send(q, 8, 1'h1);
    wait_got();
    check(i_peer.got.pop_front(), {23'h0, 1'h1, d}, "mode 1 frame");
    rdc(A_SC, 8'h57, "mode 1 flags");
    rdc(A_BUF, q, "mode 1 rx data");
    $display("test generator done");
    i_peer.bit_clks = 32;
    // mode 2 must be set while the mode view is still on
    wr(A_SC, 8'h80);
    wr(A_PC, 8'h40);
    wr(A_SC, 8'h10);
    i_peer.send(q, 9, 1'h0);
    rdc(A_SC, 8'h91, "error set");
    wr(A_SC, 8'h90);
    i_peer.send(q, 9, 1'h1);
    rdc(A_SC, 8'h91, "error sticks");
    wr(A_SC, 8'h10);
    rdc(A_SC, 8'h10, "error cleared");
    wr(A_PC, 8'h00);
    rdc(A_SC, 8'h90, "mode view");
    $display("test framing done");
    i_peer.listen = 1'h0;
    wr(A_SC, 8'h00);
    d = 8'($urandom);
    wr(A_BUF, d);
    repeat (80) @(posedge clk);
    rdc(A_SC, 8'h02, "mode 0 tx done");
    check({24'h0, m0_q}, {24'h0, d}, "mode 0 data");
    // shifter starts with the peer's start bit, so it lands in bit 0
    i_peer.bit_clks = 6;
    wr(A_SC, 8'h10);
    i_peer.send(q, 8, 1'h1);
    rdc(A_SC, 8'h11, "mode 0 rx done");
    rdc(A_BUF, {q[6:0], 1'h0}, "mode 0 rx data");
    $display("test mode 0 done");
    wr(A_RG, 8'h0E);
    wr(A_SC, 8'h40);
    i_peer.bit_clks = 128;
    i_peer.listen = 1'h1;
    // start bit waits for the first tick; all-ones data shows a running clock
    wr(A_BUF, 8'hFF);
    repeat (600) @(posedge clk);
    check(32'(i_peer.got.size()), 32'h0, "generator stopped");
    check({31'h0, txd}, 32'h0, "start bit held");
    $display("test stop done");
    print_verdict();
  end
endmodule : test_uart_with_internal_baud_generator
